//--- hw/ccr_readout.sv
// Function
// - Mode select 10 runs compensation, firing steered to track scheduled current.
// - Range 00.99 schedules in percent; in mode 10 any other range means kA maximum and kA schedule.
// - Monitoring measures and shows current, no correction, schedule taken as percent.
// - Percent selected before initiation shows measured current at sequence end.
// - Units button shows phase percent, tens shows kA, other buttons clear.
// - Toggling allowed only while an end-of-weld current result is shown.
// - Output too low at end in mode 10 sets tap raise indicator; toggling stays available.
// - Too much current at end in mode 10 sets tap lower indicator; toggling stays available.
// - Output code 12 in constant-current mode shows the end result even without percent select.
// - Window monitored: show current if inside, else flash under or over flag.
// - Code 13 also pulses the third valve for 30 mains cycles on violation.
// - Code 14 shows flag steadily, halts repeat, refuses initiations during fault.
// - Any front-panel press clears a latched limit fault and re-enables initiation.
// - Zero stored limits give default window of scheduled current plus/minus ten percent.
// - Default window for codes 12-14 and 22-27 is ten percent.
// - Program mode right button prompts lower then upper limit; enter stores value.
// - Learning setup records several weld readings and sets amplifier gain.
// - Mode select zero fires at scheduled percent without correction.
`timescale 1ns/1ps
`default_nettype none
module ccr_readout import ccr_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] mode_sel_in,
	input wire logic [15:0] range_value_in,
	input wire logic [15:0] sched_current_in,
	input wire logic [7:0] proc_code_in,
	input wire logic percent_selected_in,
	input wire logic program_mode_in,
	input wire ccr_btn_t btn_in,
	input wire logic [15:0] data_value_in,
	input wire logic init_in,
	input wire logic seq_end_in,
	input wire ccr_meas_t meas_in,
	input wire logic mains_cycle_in,
	input wire logic learn_start_in,
	output logic init_accept_out,
	output logic halt_repeat_out,
	output logic [7:0] firing_pct_out,
	output logic units_ka_out,
	output ccr_show_t disp_kind_out,
	output logic [15:0] disp_value_out,
	output logic disp_flash_out,
	output logic tap_raise_indicator_out,
	output logic tap_lower_indicator_out,
	output logic under_limit_flag_out,
	output logic over_limit_flag_out,
	output logic valve3_out,
	output ccr_prompt_t limit_prompt_out,
	output logic [15:0] amp_gain_out,
	output logic learning_out
);

	ccr_state_t s;
	ccr_state_t next_s;
	logic alarm_start;
	logic comp_mode;
	logic cc_mode;
	logic forced;
	logic window_on;
	logic show_result;
	logic use_default;
	logic [15:0] tenth;
	logic [15:0] win_lo;
	logic [16:0] win_hi;
	logic viol_hi;
	logic viol_lo;
	logic any_btn;
	logic toggle_ok;
	logic weld_end;

	// Mode decoding shared by the readout, window and firing logic.
	assign comp_mode = mode_sel_in == MODE_COMP;
	assign cc_mode = comp_mode || mode_sel_in == MODE_MON;
	assign forced = cc_mode && proc_code_in >= PO_READ &&
		proc_code_in <= PO_HALT;
	assign window_on = forced || (cc_mode && proc_code_in >= PO_WIN_LO &&
		proc_code_in <= PO_WIN_HI);
	assign show_result = forced || s.pct_sel;
	assign weld_end = seq_end_in && !s.learn;

	// A zero in either stored limit falls back to the ten percent window.
	assign use_default = s.lo_lim == LIMIT_NONE ||
		s.hi_lim == LIMIT_NONE;
	assign tenth = sched_current_in / WIN_DIV;
	assign win_lo = use_default ? sched_current_in - tenth : s.lo_lim;
	assign win_hi = use_default ? {1'b0, sched_current_in} + {1'b0, tenth} :
		{1'b0, s.hi_lim};
	assign viol_hi = window_on && {1'b0, meas_in.cur} > win_hi;
	assign viol_lo = window_on && meas_in.cur < win_lo;

	// Units and tens only toggle the readout while a current result is up.
	assign any_btn = |btn_in;
	assign toggle_ok = s.show == SHOW_CUR || s.show == SHOW_PHASE ||
		s.show == SHOW_TAP_UP || s.show == SHOW_TAP_DN;

	// Next-state logic; sequence-end events are applied last so that a
	// fault raised in the same cycle as a clearing press is not lost.
	always_comb begin
		next_s = s;
		alarm_start = 1'b0;

		// Any press clears a latched limit fault.
		if (any_btn) begin
			next_s.fault = 1'b0;
			next_s.over = 1'b0;
			next_s.under = 1'b0;
		end

		// Readout buttons in operate mode.
		if (!program_mode_in && any_btn) begin
			if (btn_in.units && toggle_ok) begin
				next_s.show = SHOW_PHASE;
			end else if (btn_in.tens && toggle_ok) begin
				next_s.show = SHOW_CUR;
			end else begin
				next_s.show = SHOW_BLANK;
				next_s.flash = 1'b0;
				next_s.tap_up = 1'b0;
				next_s.tap_dn = 1'b0;
			end
		end

		// Limit editing in program mode.
		if (!program_mode_in) begin
			next_s.prompt = PR_NONE;
		end else begin
			if (btn_in.right) begin
				unique case (s.prompt)
					PR_NONE: begin
						if (percent_selected_in) begin
							next_s.prompt = PR_LOWER;
						end
					end
					PR_LOWER: begin
						next_s.prompt = PR_UPPER;
					end
					PR_UPPER: begin
						next_s.prompt = PR_NONE;
					end
					default: begin
						next_s.prompt = PR_NONE;
					end
				endcase
			end
			if (btn_in.enter && s.prompt == PR_LOWER) begin
				next_s.lo_lim = data_value_in;
			end
			if (btn_in.enter && s.prompt == PR_UPPER) begin
				next_s.hi_lim = data_value_in;
			end
		end

		// Learning setup starts on request.
		if (learn_start_in && !s.learn) begin
			next_s.learn = 1'b1;
			next_s.learn_cnt = 3'h0;
			next_s.learn_max = 16'h0000;
		end

		// An accepted initiation drops the previous results.
		if (init_accept_out) begin
			next_s.pct_sel = percent_selected_in;
			next_s.show = SHOW_BLANK;
			next_s.flash = 1'b0;
			next_s.tap_up = 1'b0;
			next_s.tap_dn = 1'b0;
			next_s.over = 1'b0;
			next_s.under = 1'b0;
		end

		// Firing outside compensation is the scheduled percent.
		if (!comp_mode) begin
			next_s.firing = sched_current_in[7:0];
		end

		// Each learning weld records its peak reading.
		if (seq_end_in && s.learn) begin
			if (meas_in.cur > s.learn_max) begin
				next_s.learn_max = meas_in.cur;
			end
			next_s.learn_cnt = s.learn_cnt + 3'h1;
			if (s.learn_cnt == LEARN_LAST) begin
				next_s.learn = 1'b0;
				next_s.gain = meas_in.cur > s.learn_max ?
					meas_in.cur : s.learn_max;
			end
		end

		// End of a weld sequence.
		if (weld_end) begin
			next_s.hold_cur = meas_in.cur;
			next_s.hold_phase = meas_in.phase;
			if (comp_mode) begin
				if (meas_in.cur < sched_current_in && s.firing < FIRE_MAX) begin
					next_s.firing = s.firing + 8'h01;
				end else if (meas_in.cur > sched_current_in &&
					s.firing > FIRE_MIN) begin
					next_s.firing = s.firing - 8'h01;
				end
				next_s.tap_up = meas_in.too_low;
				next_s.tap_dn = meas_in.too_high;
			end
			if (viol_hi || viol_lo) begin
				next_s.show = viol_hi ? SHOW_OVER : SHOW_UNDER;
				next_s.over = viol_hi;
				next_s.under = !viol_hi;
				next_s.flash = proc_code_in != PO_HALT;
				if (proc_code_in == PO_HALT) begin
					next_s.fault = 1'b1;
				end
				if (proc_code_in == PO_ALARM) begin
					alarm_start = 1'b1;
				end
			end else if (show_result) begin
				next_s.flash = 1'b0;
				if (comp_mode && meas_in.too_low) begin
					next_s.show = SHOW_TAP_UP;
				end else if (comp_mode && meas_in.too_high) begin
					next_s.show = SHOW_TAP_DN;
				end else begin
					next_s.show = SHOW_CUR;
				end
			end
		end
	end

	// State register.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s <= ST_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Third valve alarm pulse.
	ccr_alarm_timer u_alarm (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.start_in(alarm_start),
		.mains_cycle_in(mains_cycle_in),
		.valve_out(valve3_out)
	);

	// Outputs; initiation is refused while a halt fault or learning runs.
	assign init_accept_out = init_in && !s.fault && !s.learn;
	assign halt_repeat_out = s.fault;
	assign firing_pct_out = s.firing;
	assign units_ka_out = comp_mode && range_value_in != RANGE_PCT;
	assign disp_kind_out = s.show;
	assign disp_value_out = s.show == SHOW_PHASE ? {8'h00, s.hold_phase} :
		(s.show == SHOW_BLANK ? 16'h0000 : s.hold_cur);
	assign disp_flash_out = s.flash;
	assign tap_raise_indicator_out = s.tap_up;
	assign tap_lower_indicator_out = s.tap_dn;
	assign under_limit_flag_out = s.under;
	assign over_limit_flag_out = s.over;
	assign limit_prompt_out = s.prompt;
	assign amp_gain_out = s.gain;
	assign learning_out = s.learn;

	property p_inhibit;
		@(posedge clk_in) disable iff (rst_in)
		halt_repeat_out |-> !init_accept_out;
	endproperty
	a_inhibit: assert property (p_inhibit)
	else $error("Initiation accepted during limit fault.");

	property p_fault_clear;
		@(posedge clk_in) disable iff (rst_in)
		halt_repeat_out && any_btn && !seq_end_in |=> !halt_repeat_out;
	endproperty
	a_fault_clear: assert property (p_fault_clear)
	else $error("Button press did not clear limit fault.");

	property p_halt_steady;
		@(posedge clk_in) disable iff (rst_in)
		weld_end && viol_hi && proc_code_in == PO_HALT
		|=> halt_repeat_out && over_limit_flag_out && !disp_flash_out;
	endproperty
	a_halt_steady: assert property (p_halt_steady)
	else $error("High fault under code 14 not latched steadily.");

	property p_flash;
		@(posedge clk_in) disable iff (rst_in)
		weld_end && viol_lo && proc_code_in == PO_READ
		|=> under_limit_flag_out && disp_flash_out && !halt_repeat_out;
	endproperty
	a_flash: assert property (p_flash)
	else $error("Low violation not flashed under code 12.");

	property p_default_window;
		@(posedge clk_in) disable iff (rst_in)
		weld_end && forced && use_default &&
		{1'b0, meas_in.cur} > {1'b0, sched_current_in} + {1'b0, tenth}
		|=> over_limit_flag_out;
	endproperty
	a_default_window: assert property (p_default_window)
	else $error("Default ten percent window not applied.");

	property p_forced_readout;
		@(posedge clk_in) disable iff (rst_in)
		weld_end && forced && !viol_hi && !viol_lo &&
		!meas_in.too_low && !meas_in.too_high
		|=> disp_kind_out == SHOW_CUR && disp_value_out == $past(meas_in.cur);
	endproperty
	a_forced_readout: assert property (p_forced_readout)
	else $error("Forced end readout missing.");

	property p_toggle_phase;
		@(posedge clk_in) disable iff (rst_in)
		toggle_ok && btn_in.units && !program_mode_in && !seq_end_in &&
		!init_in
		|=> disp_kind_out == SHOW_PHASE &&
		disp_value_out == {8'h00, s.hold_phase};
	endproperty
	a_toggle_phase: assert property (p_toggle_phase)
	else $error("Units button did not show phase percent.");

	property p_no_toggle;
		@(posedge clk_in) disable iff (rst_in)
		!toggle_ok && any_btn && !program_mode_in && !seq_end_in
		|=> disp_kind_out == SHOW_BLANK;
	endproperty
	a_no_toggle: assert property (p_no_toggle)
	else $error("Toggle allowed with no current result shown.");

	property p_comp_up;
		@(posedge clk_in) disable iff (rst_in)
		weld_end && comp_mode && meas_in.cur < sched_current_in &&
		s.firing < FIRE_MAX
		|=> firing_pct_out == $past(s.firing) + 8'h01;
	endproperty
	a_comp_up: assert property (p_comp_up)
	else $error("Compensation did not raise firing.");

	property p_no_correct;
		@(posedge clk_in) disable iff (rst_in)
		!comp_mode |=> firing_pct_out == $past(sched_current_in[7:0]);
	endproperty
	a_no_correct: assert property (p_no_correct)
	else $error("Firing corrected outside compensation.");

	property p_prompt;
		@(posedge clk_in) disable iff (rst_in)
		program_mode_in && btn_in.right && limit_prompt_out == PR_LOWER
		|=> limit_prompt_out == PR_UPPER;
	endproperty
	a_prompt: assert property (p_prompt)
	else $error("Second right press did not prompt upper limit.");

endmodule : ccr_readout
`default_nettype wire

//--- hw/ccr_pkg.sv
package ccr_pkg;

	// Mode select codes for off and the auto-range constant-current modes.
	localparam logic [7:0] MODE_OFF = 8'h00;
	localparam logic [7:0] MODE_COMP = 8'h0A;
	localparam logic [7:0] MODE_MON = 8'h0B;

	// Process output codes with readout, alarm and halt behaviour.
	localparam logic [7:0] PO_READ = 8'h0C;
	localparam logic [7:0] PO_ALARM = 8'h0D;
	localparam logic [7:0] PO_HALT = 8'h0E;
	localparam logic [7:0] PO_WIN_LO = 8'h16;
	localparam logic [7:0] PO_WIN_HI = 8'h1B;

	// Range value 00.99 in hundredths selects percent scheduling.
	localparam logic [15:0] RANGE_PCT = 16'h0063;
	localparam logic [15:0] LIMIT_NONE = 16'h0000;
	// Divisor giving the ten percent default window.
	localparam logic [15:0] WIN_DIV = 16'h000A;

	// Firing percent limits and start value for compensation.
	localparam logic [7:0] FIRE_MIN = 8'h14;
	localparam logic [7:0] FIRE_MAX = 8'h63;
	localparam logic [7:0] FIRE_START = 8'h4B;

	// Count index of the last of the four weld cycles recorded by the learning setup.
	localparam logic [2:0] LEARN_LAST = 3'h3;

	// Alarm duration, counted in mains cycles.
	localparam int ALARM_MS = 500;
	localparam int MAINS_HZ = 60;
	localparam int ALARM_CYCLES = ALARM_MS * MAINS_HZ / 1000;

	// What the data display shows.
	typedef enum logic [2:0] {
		SHOW_BLANK = 3'b000,
		SHOW_CUR = 3'b001,
		SHOW_PHASE = 3'b011,
		SHOW_TAP_UP = 3'b010,
		SHOW_TAP_DN = 3'b110,
		SHOW_OVER = 3'b111,
		SHOW_UNDER = 3'b101
	} ccr_show_t;

	// Limit-edit prompt on the schedule display.
	typedef enum logic [1:0] {
		PR_NONE = 2'b00,
		PR_LOWER = 2'b01,
		PR_UPPER = 2'b11
	} ccr_prompt_t;

	// Front-panel buttons, one-cycle presses.
	typedef struct packed {
		logic units;
		logic tens;
		logic right;
		logic enter;
		logic other;
	} ccr_btn_t;

	// End-of-sequence measurement from the current sensor side.
	typedef struct packed {
		logic [15:0] cur;
		logic [7:0] phase;
		logic too_low;
		logic too_high;
	} ccr_meas_t;

	// Whole state of the readout block.
	typedef struct packed {
		logic [7:0] firing;
		ccr_show_t show;
		logic flash;
		logic fault;
		logic pct_sel;
		logic tap_up;
		logic tap_dn;
		logic over;
		logic under;
		logic learn;
		logic [15:0] hold_cur;
		logic [7:0] hold_phase;
		ccr_prompt_t prompt;
		logic [15:0] lo_lim;
		logic [15:0] hi_lim;
		logic [15:0] gain;
		logic [15:0] learn_max;
		logic [2:0] learn_cnt;
	} ccr_state_t;

	localparam ccr_state_t ST_RESET = '{firing: FIRE_START,
		show: SHOW_BLANK, prompt: PR_NONE, default: '0};

	// Alarm timer state.
	typedef struct packed {
		logic on;
		logic [7:0] cnt;
	} ccr_alarm_t;

	localparam ccr_alarm_t AL_RESET = '{default: '0};

endpackage : ccr_pkg

//--- hw/ccr_alarm_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_alarm_timer import ccr_pkg::*; #(
	parameter logic [7:0] CYCLES = 8'(ALARM_CYCLES)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic mains_cycle_in,
	output logic valve_out
);

	ccr_alarm_t s;
	ccr_alarm_t next_s;

	// Counts mains cycles, not clock ticks, so the pulse follows line rate.
	always_comb begin
		next_s = s;
		if (start_in) begin
			next_s.on = 1'b1;
			next_s.cnt = CYCLES;
		end else if (s.on && mains_cycle_in) begin
			if (s.cnt == 8'h01) begin
				next_s.on = 1'b0;
				next_s.cnt = 8'h00;
			end else begin
				next_s.cnt = s.cnt - 8'h01;
			end
		end
	end

	// State register.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s <= AL_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign valve_out = s.on;

	property p_alarm_start;
		@(posedge clk_in) disable iff (rst_in)
		start_in |=> valve_out && s.cnt == CYCLES;
	endproperty
	a_alarm_start: assert property (p_alarm_start)
	else $error("Alarm valve did not start with full count.");

	property p_alarm_end;
		@(posedge clk_in) disable iff (rst_in)
		valve_out && !start_in && mains_cycle_in && s.cnt == 8'h01
		|=> !valve_out;
	endproperty
	a_alarm_end: assert property (p_alarm_end)
	else $error("Alarm valve outlasted its mains cycle count.");

	property p_alarm_hold;
		@(posedge clk_in) disable iff (rst_in)
		valve_out && !mains_cycle_in |=> valve_out;
	endproperty
	a_alarm_hold: assert property (p_alarm_hold)
	else $error("Alarm valve dropped between mains cycles.");

endmodule : ccr_alarm_timer
`default_nettype wire

//--- tb/ccr_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_sense_model import ccr_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic fire_in,
	input wire ccr_meas_t want_in,
	output logic mains_cycle_out,
	output logic seq_end_out,
	output ccr_meas_t meas_out
);
	logic [3:0] phase;
	logic pend;
	ccr_meas_t last;
	// A weld ends only at mains phase 4, clear of the mains pulse.
	// That keeps the alarm count from racing a pulse at its start.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			phase <= '0;
			pend <= 1'b0;
			seq_end_out <= 1'b0;
			last <= '0;
		end else begin
			phase <= phase + 4'h1;
			seq_end_out <= pend && phase == 4'h4;
			if (fire_in) begin
				pend <= 1'b1;
			end else if (phase == 4'h4) begin
				pend <= 1'b0;
			end
			if (pend && phase == 4'h4) begin
				last <= want_in;
			end
		end
	end
	// Outside its valid cycle the measurement shows the inverse pattern.
	assign meas_out = seq_end_out ? last : ~last;
	assign mains_cycle_out = phase == 4'h0;
endmodule : ccr_sense_model
`default_nettype wire

//--- tb/ccr_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_readout_tb import ccr_pkg::*; ;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] mode = MODE_OFF;
	logic [15:0] rng = RANGE_PCT;
	logic [15:0] sched = 16'h0032;
	logic [7:0] code = 8'h00;
	logic pct = 1'b0;
	logic prog = 1'b0;
	ccr_btn_t btn = '0;
	logic [15:0] dv = '0;
	logic init_in = 1'b0;
	logic lstart = 1'b0;
	logic fire = 1'b0;
	ccr_meas_t want = '0;
	wire logic seq_end, mains, accept, halt, ka, flash, t_up, t_dn;
	wire logic under, over, valve, learning;
	wire ccr_meas_t meas;
	wire logic [7:0] firing;
	wire ccr_show_t kind;
	wire logic [15:0] value, gain;
	wire ccr_prompt_t prompt;
	int fails = 0;
	int checks = 0;
	logic [31:0] r = 32'h559737E8;
	ccr_readout ccr_readout_i (.clk_in(clk_in), .rst_in(rst_in),
		.mode_sel_in(mode), .range_value_in(rng), .sched_current_in(sched),
		.proc_code_in(code), .percent_selected_in(pct),
		.program_mode_in(prog), .btn_in(btn), .data_value_in(dv),
		.init_in(init_in), .seq_end_in(seq_end), .meas_in(meas),
		.mains_cycle_in(mains), .learn_start_in(lstart),
		.init_accept_out(accept), .halt_repeat_out(halt),
		.firing_pct_out(firing), .units_ka_out(ka), .disp_kind_out(kind),
		.disp_value_out(value), .disp_flash_out(flash),
		.tap_raise_indicator_out(t_up), .tap_lower_indicator_out(t_dn),
		.under_limit_flag_out(under), .over_limit_flag_out(over),
		.valve3_out(valve), .limit_prompt_out(prompt),
		.amp_gain_out(gain), .learning_out(learning));
	ccr_sense_model ccr_sense_model_i (.clk_in(clk_in), .rst_in(rst_in),
		.fire_in(fire), .want_in(want), .mains_cycle_out(mains),
		.seq_end_out(seq_end), .meas_out(meas));
	// Clock of 25 ns period.
	always #12.5 clk_in = ~clk_in;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {1'b0, x[31:1]} ^ (x[0] ? 32'hA3000000 : 32'h0);
	endfunction : lfsr
	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Ends a weld with the given result and waits until it is taken.
	task automatic sense(input logic [15:0] c, input logic [7:0] p,
		input logic tl, input logic th);
		int n;
		@(posedge clk_in);
		want <= '{cur: c, phase: p, too_low: tl, too_high: th};
		fire <= 1'b1;
		@(posedge clk_in);
		fire <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (seq_end !== 1'b1 && n < 40);
		// A weld end that never comes is a mismatch, not a silent pass.
		chk("seq_end", 16'h0001, 16'(seq_end));
		#1;
	endtask : sense
	task automatic weld(input logic [15:0] c, input logic [7:0] p,
		input logic tl, input logic th);
		@(posedge clk_in);
		init_in <= 1'b1;
		@(posedge clk_in);
		init_in <= 1'b0;
		sense(c, p, tl, th);
	endtask : weld
	task automatic press(input ccr_btn_t b, input logic [15:0] d);
		@(posedge clk_in);
		btn <= b;
		dv <= d;
		@(posedge clk_in);
		btn <= '0;
		#1;
	endtask : press
	// A hang counts as a mismatch; the whole run needs far less time.
	initial begin
		#(25 * 20000);
		fails++;
		report_and_stop();
	end
	initial begin
		logic [15:0] s, w, c, mx;
		int i, n;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk("kind", 16'(SHOW_BLANK), 16'(kind));
		chk("reset", 16'h0000, 16'({valve, halt, under, over, t_up, t_dn,
			flash, learning, accept}));
		chk("prompt", 16'(PR_NONE), 16'(prompt));
		chk("gain", 16'h0000, gain);
		chk("firing", 16'h0032, 16'(firing));
		chk("ka", 16'h0000, 16'(ka));
		@(posedge clk_in);
		mode <= MODE_COMP;
		rng <= 16'h0500;
		#1 chk("ka", 16'h0001, 16'(ka));
		@(posedge clk_in);
		rng <= RANGE_PCT;
		#1 chk("ka", 16'h0000, 16'(ka));
		@(posedge clk_in);
		mode <= MODE_MON;
		code <= PO_READ;
		#1 chk("ka", 16'h0000, 16'(ka));
		// Default window: inside, top edge, just under, just over.
		for (i = 0; i < 8; i++) begin
			r = lfsr(r);
			s = 16'h00C8 + 16'(r[7:0]);
			w = s / 16'h000A;
			case (i % 4)
				0: c = s - w + (16'(r[15:8]) % (w + w + 16'h0001));
				1: c = s + w;
				2: c = s - w - 16'h0001;
				default: c = s + w + 16'h0001;
			endcase
			@(posedge clk_in);
			sched <= s;
			weld(c, r[23:16], 1'b0, 1'b0);
			chk("kind", (i % 4 < 2) ? 16'(SHOW_CUR) : (i % 4 == 2) ?
				16'(SHOW_UNDER) : 16'(SHOW_OVER), 16'(kind));
			chk("value", c, value);
			chk("flags", 16'(i % 4 > 1), 16'(flash));
			chk("under", 16'(i % 4 == 2), 16'(under));
			chk("over", 16'(i % 4 == 3), 16'(over));
			chk("valve", 16'h0000, 16'(valve));
		end
		// Alarm code: count mains pulses while the valve is on.
		code <= PO_ALARM;
		weld(s - w - 16'h0010, 8'h40, 1'b0, 1'b0);
		chk("valve", 16'h0001, 16'(valve));
		chk("flash", 16'h0001, 16'(flash));
		n = 0;
		for (i = 0; i < 1000; i++) begin
			@(posedge clk_in);
			if (valve !== 1'b1) break;
			if (mains === 1'b1) n++;
		end
		chk("alarm", 16'h001E, 16'(n));
		code <= PO_HALT;
		weld(s + w + 16'h0010, 8'h40, 1'b0, 1'b0);
		chk("kind", 16'(SHOW_OVER), 16'(kind));
		chk("flash", 16'h0000, 16'(flash));
		chk("halt", 16'h0001, 16'(halt));
		@(posedge clk_in);
		init_in <= 1'b1;
		#1 chk("accept", 16'h0000, 16'(accept));
		r = lfsr(r);
		press(ccr_btn_t'(5'h01 << (r[7:0] % 8'h05)), 16'h0000);
		chk("accept", 16'h0001, 16'(accept));
		chk("halt", 16'h0000, 16'(halt));
		init_in <= 1'b0;
		// Readout chosen by percent select; toggling with data buttons.
		code <= PO_WIN_LO;
		pct <= 1'b1;
		weld(s, 8'h37, 1'b0, 1'b0);
		chk("kind", 16'(SHOW_CUR), 16'(kind));
		press(5'h10, 16'h0000);
		chk("kind", 16'(SHOW_PHASE), 16'(kind));
		chk("value", 16'h0037, value);
		press(5'h08, 16'h0000);
		repeat (5) @(posedge clk_in);
		#1 chk("kind", 16'(SHOW_CUR), 16'(kind));
		chk("value", s, value);
		press(5'h01, 16'h0000);
		chk("kind", 16'(SHOW_BLANK), 16'(kind));
		press(5'h10, 16'h0000);
		chk("kind", 16'(SHOW_BLANK), 16'(kind));
		pct <= 1'b0;
		weld(s, 8'h37, 1'b0, 1'b0);
		chk("kind", 16'(SHOW_BLANK), 16'(kind));
		// Compensation steps firing and raises tap indicators. Firing
		// first settles on the new schedule while still monitoring, and
		// percent is selected because tap messages need a result view.
		code <= 8'h00;
		sched <= 16'h0032;
		pct <= 1'b1;
		@(posedge clk_in);
		mode <= MODE_COMP;
		#1 chk("firing", 16'h0032, 16'(firing));
		weld(16'h0020, 8'h50, 1'b1, 1'b0);
		chk("firing", 16'h0033, 16'(firing));
		chk("kind", 16'(SHOW_TAP_UP), 16'(kind));
		chk("raise", 16'h0001, 16'(t_up));
		press(5'h10, 16'h0000);
		chk("kind", 16'(SHOW_PHASE), 16'(kind));
		weld(16'h0040, 8'h50, 1'b0, 1'b1);
		chk("firing", 16'h0032, 16'(firing));
		chk("kind", 16'(SHOW_TAP_DN), 16'(kind));
		chk("lower", 16'h0001, 16'(t_dn));
		press(5'h08, 16'h0000);
		chk("value", 16'h0040, value);
		// Program a wide stored window for plain readout.
		prog <= 1'b1;
		pct <= 1'b1;
		press(5'h04, 16'h0000);
		chk("prompt", 16'(PR_LOWER), 16'(prompt));
		press(5'h02, 16'h000A);
		press(5'h04, 16'h0000);
		chk("prompt", 16'(PR_UPPER), 16'(prompt));
		press(5'h02, 16'h0063);
		press(5'h04, 16'h0000);
		chk("prompt", 16'(PR_NONE), 16'(prompt));
		prog <= 1'b0;
		mode <= MODE_MON;
		code <= PO_READ;
		sched <= 16'h0030;
		weld(16'h0014, 8'h20, 1'b0, 1'b0);
		chk("kind", 16'(SHOW_CUR), 16'(kind));
		weld(16'h0070, 8'h20, 1'b0, 1'b0);
		chk("kind", 16'(SHOW_OVER), 16'(kind));
		// Learning records four welds and keeps the largest.
		@(posedge clk_in);
		lstart <= 1'b1;
		@(posedge clk_in);
		lstart <= 1'b0;
		#1 chk("learning", 16'h0001, 16'(learning));
		mx = '0;
		for (i = 0; i < 4; i++) begin
			r = lfsr(r);
			mx = (r[15:0] > mx) ? r[15:0] : mx;
			sense(r[15:0], 8'h10, 1'b0, 1'b0);
		end
		chk("gain", mx, gain);
		chk("learning", 16'h0000, 16'(learning));
		report_and_stop();
	end
endmodule : ccr_readout_tb
`default_nettype wire
